//--- common/pll_ctrl_pkg.sv
// package for the pll latch program control block
// assumes a single 25 MHz system clock samples every pin
package pll_ctrl_pkg;
  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  localparam int REF_DIV_LSB = 2;
  localparam int REF_DIV_W = 14;
  localparam int ABW_LSB = 16;
  localparam int TEST_LSB = 18;
  localparam int LDP_POS = 20;
  localparam int FB_DIV_LSB = 8;
  localparam int FB_DIV_W = 13;
  localparam int GAIN_POS = 21;
  localparam int CRST_POS = 2;
  localparam int PD1_POS = 3;
  localparam int OSEL_LSB = 4;
  localparam int POL_POS = 7;
  localparam int TRI_POS = 8;
  localparam int FLE_POS = 9;
  localparam int FLM_POS = 10;
  localparam int TC_LSB = 11;
  localparam int CUR1_LSB = 15;
  localparam int CUR2_LSB = 18;
  localparam int PD2_POS = 21;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TIMEOUT_UNIT = 4;
  localparam int TIMEOUT_CNT_W = 8;
  localparam int LOCK_FAST = 3;
  localparam int LOCK_SLOW = 5;
  localparam int LOCK_CNT_W = 3;

  typedef struct packed {
    logic [REF_DIV_W-1:0] ref_div;
    logic [1:0] antibacklash;
    logic [1:0] test_mode;
    logic lock_detect_precision;
  } ref_cfg_t;

  typedef struct packed {
    logic counter_reset_bit;
    logic power_down_first;
    logic [2:0] output_select;
    logic detector_polarity_bit;
    logic pump_tristate_bit;
    logic fastlock_enable_bit;
    logic fastlock_mode_bit;
    logic [3:0] timeout_code;
    logic [2:0] current_one;
    logic [2:0] current_two;
    logic power_down_second;
  } func_cfg_t;

  typedef enum logic [2:0] {
    PWR_ON = 3'h1,
    PWR_WAIT = 3'h2,
    PWR_DOWN = 3'h4
  } pwr_state_t;

  // timeout code to cycles, computed as (code + 1) times TIMEOUT_UNIT
  function automatic logic [TIMEOUT_CNT_W-1:0] timeout_cycles(input logic [3:0] code);
    timeout_cycles = TIMEOUT_CNT_W'((int'(code) + 1) * TIMEOUT_UNIT);
  endfunction
endpackage

//--- hdl/serial_shifter.sv
// serial input shift register with load strobe edge detect
// assumes raw pins; synchronises clock, data and strobe itself
`timescale 1ns/1ps
module serial_shifter (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic load_strobe_in,
  output logic [pll_ctrl_pkg::WORD_W-1:0] word_out,
  output logic load_out
);
  import pll_ctrl_pkg::*;
  logic [2:0] clk_sync_ff, nxt_clk_sync;
  logic [1:0] dat_sync_ff, nxt_dat_sync;
  logic [2:0] le_sync_ff, nxt_le_sync;
  logic [WORD_W-1:0] shift_ff, nxt_shift;
  logic [WORD_W-1:0] word_ff, nxt_word;
  logic load_ff, nxt_load;

  // ----------------------------------------------------------------
  // shift msb first on sclk rise, capture on strobe rise
  // ----------------------------------------------------------------
  always_comb begin
    nxt_clk_sync = {clk_sync_ff[1:0], sclk_in};
    nxt_dat_sync = {dat_sync_ff[0], sdata_in};
    nxt_le_sync = {le_sync_ff[1:0], load_strobe_in};
    nxt_shift = shift_ff;
    nxt_word = word_ff;
    nxt_load = 1'b0;
    // data is taken from its second stage, the same depth as the newer clock sample of the edge
    if (clk_sync_ff[1] && !clk_sync_ff[2]) begin
      nxt_shift = {shift_ff[WORD_W-2:0], dat_sync_ff[1]};
    end
    if (le_sync_ff[1] && !le_sync_ff[2]) begin
      nxt_word = shift_ff;
      nxt_load = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      clk_sync_ff <= 3'h0;
      dat_sync_ff <= 2'h0;
      le_sync_ff <= 3'h0;
      shift_ff <= '0;
      word_ff <= '0;
      load_ff <= 1'b0;
    end else begin
      clk_sync_ff <= nxt_clk_sync;
      dat_sync_ff <= nxt_dat_sync;
      le_sync_ff <= nxt_le_sync;
      shift_ff <= nxt_shift;
      word_ff <= nxt_word;
      load_ff <= nxt_load;
    end
  end

  assign word_out = word_ff;
  assign load_out = load_ff;
endmodule // serial_shifter

//--- hdl/lock_detector.sv
// digital lock detect over detector cycles
// assumes per-cycle small/large error flags from the same clock domain
`timescale 1ns/1ps
module lock_detector (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic precision_in,
  input wire logic cycle_in,
  input wire logic err_small_in,
  input wire logic err_large_in,
  output logic locked_out
);
  import pll_ctrl_pkg::*;
  logic [LOCK_CNT_W-1:0] good_ff, nxt_good;
  logic locked_ff, nxt_locked;
  logic [LOCK_CNT_W-1:0] need;

  // ----------------------------------------------------------------
  // count consecutive good cycles, drop on a large error
  // ----------------------------------------------------------------
  always_comb begin
    need = precision_in ? LOCK_CNT_W'(LOCK_SLOW) : LOCK_CNT_W'(LOCK_FAST);
    nxt_good = good_ff;
    nxt_locked = locked_ff;
    if (clear_in) begin
      nxt_good = '0;
      nxt_locked = 1'b0;
    end else if (cycle_in) begin
      if (err_large_in) begin
        nxt_good = '0;
        nxt_locked = 1'b0;
      end else if (err_small_in) begin
        if (good_ff + 1'b1 >= need) nxt_locked = 1'b1;
        if (good_ff != need) nxt_good = good_ff + 1'b1;
      end else begin
        nxt_good = '0; // middle band breaks the run but keeps lock
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      good_ff <= '0;
      locked_ff <= 1'b0;
    end else begin
      good_ff <= nxt_good;
      locked_ff <= nxt_locked;
    end
  end

  assign locked_out = locked_ff;
endmodule // lock_detector

//--- hdl/pll_latch_program_control.sv
// pll latch program control: serial latches, power-down and fastlock
// assumes counters outside follow hold/load; pump events come as pulses
`timescale 1ns/1ps
module pll_latch_program_control (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic load_strobe_in,
  input wire logic chip_enable_in,
  input wire logic pump_event_in,
  input wire logic pd_cycle_in,
  input wire logic err_small_in,
  input wire logic err_large_in,
  output pll_ctrl_pkg::ref_cfg_t ref_cfg_out,
  output pll_ctrl_pkg::func_cfg_t func_cfg_out,
  output logic [pll_ctrl_pkg::FB_DIV_W-1:0] fb_div_out,
  output logic gain_boost_bit_out,
  output logic [2:0] pump_current_out,
  output logic pump_oe_out,
  output logic counters_hold_out,
  output logic power_down_out,
  output logic reset_pulse_out,
  output logic lock_detect_out
);
  import pll_ctrl_pkg::*;

  logic [WORD_W-1:0] word;
  logic load;
  logic ce_meta_ff, ce_sync_ff;
  logic nxt_ce_meta, nxt_ce_sync;
  ref_cfg_t ref_ff, nxt_ref;
  func_cfg_t func_ff, nxt_func;
  logic [FB_DIV_W-1:0] fb_ff, nxt_fb;
  logic gain_ff, nxt_gain;
  logic fb_pending_ff, nxt_fb_pending;
  logic pulse_ff, nxt_pulse;
  logic [TIMEOUT_CNT_W-1:0] tmo_ff, nxt_tmo;
  pwr_state_t pwr_ff, nxt_pwr;
  logic pd_any;
  logic fastlock_active;
  logic [2:0] cur_ff, nxt_cur;

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  serial_shifter u_shift (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .sclk_in(sclk_in),
    .sdata_in(sdata_in),
    .load_strobe_in(load_strobe_in),
    .word_out(word),
    .load_out(load)
  );

  lock_detector u_lock (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(pd_any),
    .precision_in(ref_ff.lock_detect_precision),
    .cycle_in(pd_cycle_in),
    .err_small_in(err_small_in),
    .err_large_in(err_large_in),
    .locked_out(lock_detect_out)
  );

  // decode a function-layout word, shared by function and init loads
  function automatic func_cfg_t decode_func(input logic [WORD_W-1:0] w);
    func_cfg_t f;
    f.counter_reset_bit = w[CRST_POS];
    f.power_down_first = w[PD1_POS];
    f.output_select = w[OSEL_LSB +: 3];
    f.detector_polarity_bit = w[POL_POS];
    f.pump_tristate_bit = w[TRI_POS];
    f.fastlock_enable_bit = w[FLE_POS];
    f.fastlock_mode_bit = w[FLM_POS];
    f.timeout_code = w[TC_LSB +: 4];
    f.current_one = w[CUR1_LSB +: 3];
    f.current_two = w[CUR2_LSB +: 3];
    f.power_down_second = w[PD2_POS];
    return f;
  endfunction

  // ----------------------------------------------------------------
  // chip enable synchroniser
  // ----------------------------------------------------------------
  // two stages before anything reads the pin
  always_comb begin
    nxt_ce_meta = chip_enable_in;
    nxt_ce_sync = ce_meta_ff;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ce_meta_ff <= 1'b0;
      ce_sync_ff <= 1'b0;
    end else begin
      ce_meta_ff <= nxt_ce_meta;
      ce_sync_ff <= nxt_ce_sync;
    end
  end

  // ----------------------------------------------------------------
  // latches, gain bit and timeout counter
  // ----------------------------------------------------------------
  // latches are never cleared by power-down so chip enable cycling is cheap
  always_comb begin
    nxt_ref = ref_ff;
    nxt_func = func_ff;
    nxt_fb = fb_ff;
    nxt_gain = gain_ff;
    nxt_fb_pending = fb_pending_ff;
    nxt_pulse = 1'b0;
    nxt_tmo = tmo_ff;
    // timeout runs only while boosted in mode two
    if (pd_any || pulse_ff) begin
      nxt_tmo = '0;
    end else if (gain_ff && func_ff.fastlock_enable_bit && func_ff.fastlock_mode_bit) begin
      if (tmo_ff >= timeout_cycles(func_ff.timeout_code) - 1'b1) begin
        nxt_gain = 1'b0;
        nxt_tmo = '0;
      end else begin
        nxt_tmo = tmo_ff + 1'b1;
      end
    end else begin
      nxt_tmo = '0;
    end
    // a fresh feedback load overrides the timeout clear in the same cycle
    if (load) begin
      case (word[1:0])
        SEL_REF: begin
          nxt_ref.ref_div = word[REF_DIV_LSB +: REF_DIV_W];
          nxt_ref.antibacklash = word[ABW_LSB +: 2];
          nxt_ref.test_mode = word[TEST_LSB +: 2];
          nxt_ref.lock_detect_precision = word[LDP_POS];
        end
        SEL_FB: begin
          nxt_fb = word[FB_DIV_LSB +: FB_DIV_W];
          nxt_gain = word[GAIN_POS];
          nxt_tmo = '0;
          if (fb_pending_ff) begin
            nxt_pulse = 1'b1;
            nxt_fb_pending = 1'b0;
          end
        end
        SEL_FUNC: begin
          nxt_func = decode_func(word);
        end
        SEL_INIT: begin
          nxt_func = decode_func(word);
          nxt_pulse = 1'b1;
          nxt_fb_pending = 1'b1;
        end
        default: begin
          nxt_func = func_ff;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ref_ff <= '0;
      func_ff <= '0;
      fb_ff <= '0;
      gain_ff <= 1'b0;
      fb_pending_ff <= 1'b0;
      pulse_ff <= 1'b0;
      tmo_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
      func_ff <= nxt_func;
      fb_ff <= nxt_fb;
      gain_ff <= nxt_gain;
      fb_pending_ff <= nxt_fb_pending;
      pulse_ff <= nxt_pulse;
      tmo_ff <= nxt_tmo;
    end
  end

  // ----------------------------------------------------------------
  // power-down state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_ON: begin
        if (func_ff.power_down_first && func_ff.power_down_second) begin
          nxt_pwr = PWR_WAIT;
        end else if (func_ff.power_down_first) begin
          nxt_pwr = PWR_DOWN;
        end
      end
      PWR_WAIT: begin
        if (!func_ff.power_down_first) nxt_pwr = PWR_ON;
        else if (!func_ff.power_down_second) nxt_pwr = PWR_DOWN;
        else if (pump_event_in) nxt_pwr = PWR_DOWN;
      end
      PWR_DOWN: begin
        if (!func_ff.power_down_first) nxt_pwr = PWR_ON;
      end
      default: nxt_pwr = PWR_ON;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) pwr_ff <= PWR_ON;
    else pwr_ff <= nxt_pwr;
  end

  // chip enable overrides the programmed bits without touching them
  assign pd_any = !ce_sync_ff || (pwr_ff == PWR_DOWN);
  assign fastlock_active = func_ff.fastlock_enable_bit && gain_ff;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur = fastlock_active ? func_ff.current_two : func_ff.current_one;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) cur_ff <= 3'h0;
    else cur_ff <= nxt_cur;
  end

  assign ref_cfg_out = ref_ff;
  assign func_cfg_out = func_ff;
  assign fb_div_out = fb_ff;
  assign gain_boost_bit_out = gain_ff;
  assign pump_current_out = cur_ff;
  // releasing counter reset frees both counters on the same edge
  assign counters_hold_out = func_ff.counter_reset_bit || pd_any || pulse_ff;
  assign pump_oe_out = !(func_ff.pump_tristate_bit || counters_hold_out);
  assign power_down_out = pd_any;
  assign reset_pulse_out = pulse_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ce_down;
    @(posedge mclk_in) disable iff (sys_rst_in) !ce_sync_ff |-> power_down_out;
  endproperty
  a_ce_down: assert property (p_ce_down) else $error("ce low without power-down");

  property p_async_pd;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (pwr_ff == PWR_ON && func_ff.power_down_first && !func_ff.power_down_second)
      |=> power_down_out;
  endproperty
  a_async_pd: assert property (p_async_pd) else $error("async power-down late");

  property p_sync_wait;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (pwr_ff == PWR_WAIT && !pump_event_in && func_ff.power_down_second
       && func_ff.power_down_first) |=> pwr_ff == PWR_WAIT;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync power-down early");

  property p_pd_effects;
    @(posedge mclk_in) disable iff (sys_rst_in)
      pd_any |-> (counters_hold_out && !pump_oe_out) ##1 (!lock_detect_out || !pd_any);
  endproperty
  a_pd_effects: assert property (p_pd_effects) else $error("power-down effects missing");

  property p_init_pulse;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (load && word[1:0] == SEL_INIT) |=> (reset_pulse_out && fb_pending_ff);
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("init load gave no pulse");

  property p_fb_pulse;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (load && word[1:0] == SEL_FB) |=> (reset_pulse_out == $past(fb_pending_ff));
  endproperty
  a_fb_pulse: assert property (p_fb_pulse) else $error("feedback pulse wrong");

  property p_current;
    @(posedge mclk_in) disable iff (sys_rst_in)
      ##1 pump_current_out == ($past(fastlock_active) ? $past(func_ff.current_two)
                                                      : $past(func_ff.current_one));
  endproperty
  a_current: assert property (p_current) else $error("pump current wrong");

  property p_mode1_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (gain_ff && !func_ff.fastlock_mode_bit && !load) |=> gain_ff;
  endproperty
  a_mode1_hold: assert property (p_mode1_hold) else $error("mode one left fastlock");

  property p_tmo_idle;
    @(posedge mclk_in) disable iff (sys_rst_in)
      !func_ff.fastlock_mode_bit |=> tmo_ff == '0;
  endproperty
  a_tmo_idle: assert property (p_tmo_idle) else $error("timeout ran outside mode two");

  property p_tristate;
    @(posedge mclk_in) disable iff (sys_rst_in) func_ff.pump_tristate_bit |-> !pump_oe_out;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pump driven while tristated");
endmodule // pll_latch_program_control

//--- test/host_model.sv
// host model: drives the three-wire serial programming link
// assumes the device samples these pins with its own clock
`timescale 1ns/1ps
module host_model (
  output logic sclk_out,
  output logic sdata_out,
  output logic load_strobe_out
);
  localparam time HALF = 160ns;
  // idle levels at time zero
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    load_strobe_out = 1'b0;
  end
  // ----------------------------------------------------------------
  // word transfer
  // ----------------------------------------------------------------
  // clock stands low between frames; data shows the inverse of its last bit
  // so a stale value can never pass for a fresh one
  task automatic send(input logic [23:0] word);
    #7;
    load_strobe_out = 1'b0; // strobe low while shifting
    #HALF;
    for (int i = 23; i >= 0; i--) begin
      sdata_out = word[i]; // msb first, 24 bits
      #HALF sclk_out = 1'b1;
      #HALF sclk_out = 1'b0;
    end
    sdata_out = ~word[0];
    #HALF load_strobe_out = 1'b1; // transfer on strobe rise
    #HALF;
  endtask
endmodule // host_model

//--- test/tb_top.sv
// testbench: programs the latch block over the serial link, checks its outputs
// assumes host_model drives the serial pins at an unrelated phase
`timescale 1ns/1ps
module tb_top;
  import pll_ctrl_pkg::*;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ce = 1'b0, pev = 1'b0, pdc = 1'b0, es = 1'b0, el = 1'b0;
  logic sclk, sdata, strobe, gain, pump_oe, hold, pdown, rpulse, lock;
  ref_cfg_t ref_cfg, xr;
  func_cfg_t func_cfg;
  logic [FB_DIV_W-1:0] fb_div, xn;
  logic [2:0] cur, c1, c2;
  logic [3:0] tc;
  logic [23:0] w, g;
  int err_total = 0, check_count = 0, pulses = 0, hi_len = 0, last_len = 0, d;

  host_model host (.sclk_out(sclk), .sdata_out(sdata), .load_strobe_out(strobe));
  pll_latch_program_control uut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .sdata_in(sdata),
    .load_strobe_in(strobe), .chip_enable_in(ce), .pump_event_in(pev),
    .pd_cycle_in(pdc), .err_small_in(es), .err_large_in(el),
    .ref_cfg_out(ref_cfg), .func_cfg_out(func_cfg), .fb_div_out(fb_div),
    .gain_boost_bit_out(gain), .pump_current_out(cur), .pump_oe_out(pump_oe),
    .counters_hold_out(hold), .power_down_out(pdown), .reset_pulse_out(rpulse),
    .lock_detect_out(lock));

  // ----------------------------------------------------------------
  // expectations and helpers
  // ----------------------------------------------------------------
  function automatic ref_cfg_t xref(input logic [23:0] v);
    return {v[15:2], v[17:16], v[19:18], v[20]};
  endfunction
  function automatic func_cfg_t xfunc(input logic [23:0] v);
    return {v[2], v[3], v[6:4], v[7], v[8], v[9], v[10], v[14:11], v[17:15], v[20:18],
      v[21]};
  endfunction
  // function word; output select and polarity random, reserved bits zero
  function automatic logic [23:0] fw(input logic pd2, pd1, crst, flm, fle, tri_b,
      input logic [3:0] t, input logic [1:0] sel);
    return {2'h0, pd2, c2, c1, t, flm, fle, tri_b, 1'($urandom), 3'($urandom), pd1, crst, sel};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // latch outputs settle about four cycles after the strobe rise
  task automatic wr(input logic [23:0] v);
    host.send(v);
    repeat (12) @(posedge mclk_in);
  endtask
  task automatic cyc(input logic s, input logic l);
    @(posedge mclk_in);
    pdc <= 1'b1;
    es <= s;
    el <= l;
    @(posedge mclk_in);
    pdc <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // clock and watchdog; the run needs well under a millisecond
  initial forever #20 mclk_in = ~mclk_in;
  initial begin
    #2ms;
    err_total++;
    end_of_test();
  end
  // count reset pulses and the length of each gain-high run
  always @(posedge mclk_in) begin
    if (rpulse === 1'b1) pulses <= pulses + 1;
    if (gain === 1'b1) hi_len <= hi_len + 1;
    else begin
      if (hi_len != 0) last_len <= hi_len;
      hi_len <= 0;
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    w = 24'($urandom(83));
    c1 = 3'h2;
    c2 = 3'h5;
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    ce <= 1'b1;
    repeat (5) @(posedge mclk_in);
    // initialization start-up
    w = fw(0, 0, 0, 0, 0, 0, 4'h3, 2'h3);
    wr(w);
    chk(24'(func_cfg), 24'(xfunc(w)));
    chk(24'(pulses), 24'h1);
    w = fw(0, 0, 0, 0, 0, 0, 4'h6, 2'h2);
    wr(w);
    chk(24'(func_cfg), 24'(xfunc(w)));
    w = {4'h0, 18'($urandom), 2'h0};
    xr = xref(w);
    wr(w);
    chk(24'(ref_cfg), 24'(xr));
    w = {3'h0, 13'($urandom), 6'h0, 2'h1};
    xn = w[20:8];
    wr(w);
    chk(24'(fb_div), 24'(xn));
    chk(24'(pulses), 24'h2);
    wr(w);
    chk(24'(pulses), 24'h2);
    chk(24'({hold, pump_oe, pdown, cur}), 24'({3'h2, c1}));
    // random loads must reach only the latch their low bits select
    for (int i = 0; i < 8; i++) begin
      w = {3'h0, 19'($urandom), 1'b0, 1'($urandom)};
      if (w[0]) xn = w[20:8];
      else xr = xref(w);
      wr(w);
      chk(24'(fb_div), 24'(xn));
      chk(24'(ref_cfg), 24'(xr));
    end
    wr(fw(0, 0, 0, 0, 0, 1, 4'h0, 2'h2));
    chk(24'({pump_oe, hold}), 24'h0);
    // counter reset start-up
    wr(fw(0, 0, 1, 0, 0, 0, 4'h0, 2'h2));
    chk(24'({pump_oe, hold, pdown}), 24'h2);
    wr({4'h0, 18'($urandom), 2'h0});
    wr({3'h0, 13'($urandom), 6'h0, 2'h1});
    wr(fw(0, 0, 0, 0, 0, 0, 4'h0, 2'h2));
    chk(24'({pump_oe, hold}), 24'h2);
    // chip enable start-up; loads still latch while down
    ce <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(24'({pdown, pump_oe, hold}), 24'h5);
    w = {4'h0, 18'($urandom), 2'h0};
    xr = xref(w);
    wr(w);
    w = fw(0, 0, 0, 0, 0, 0, 4'h1, 2'h2);
    wr(w);
    ce <= 1'b1;
    repeat (30) @(posedge mclk_in);
    chk(24'(pdown), 24'h0);
    chk(24'(ref_cfg), 24'(xr));
    chk(24'(func_cfg), 24'(xfunc(w)));
    // programmed power-down, immediate then gated by a pump event
    wr(fw(0, 1, 0, 0, 0, 0, 4'h0, 2'h2));
    chk(24'(pdown), 24'h1);
    wr(fw(0, 0, 0, 0, 0, 0, 4'h0, 2'h2));
    wr(fw(1, 1, 0, 0, 0, 0, 4'h0, 2'h2));
    chk(24'(pdown), 24'h0);
    pev <= 1'b1;
    @(posedge mclk_in);
    pev <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk(24'({pdown, pump_oe, hold}), 24'h5);
    wr(fw(0, 0, 0, 0, 0, 0, 4'h0, 2'h2));
    chk(24'(pdown), 24'h0);
    // fastlock: off, then mode one, then mode two over several codes
    c1 = 3'($urandom);
    c2 = ~c1;
    g = {2'h0, 1'b1, 13'($urandom), 6'h0, 2'h1};
    wr(fw(0, 0, 0, 0, 0, 0, 4'h0, 2'h2));
    wr(g);
    chk(24'({gain, cur}), 24'({1'b1, c1}));
    wr(fw(0, 0, 0, 0, 1, 0, 4'h0, 2'h2));
    wr(g);
    repeat (150) @(posedge mclk_in);
    chk(24'({gain, cur}), 24'({1'b1, c2}));
    g[21] = 1'b0;
    wr(g);
    chk(24'({gain, cur}), 24'({1'b0, c1}));
    g[21] = 1'b1;
    for (int i = 0; i < 5; i++) begin
      tc = (i < 2) ? {4{i[0]}} : 4'($urandom);
      wr(fw(0, 0, 0, 1, 1, 0, tc, 2'h2));
      last_len = 0;
      wr(g);
      repeat (70) @(posedge mclk_in);
      d = last_len - 4 * (int'(tc) + 1);
      chk(24'(d inside {-1, 0, 1}), 24'h1);
      chk(24'({gain, cur}), 24'({1'b0, c1}));
    end
    // lock detect, three good cycles then five with precision set
    cyc(1, 0);
    cyc(1, 0);
    chk(24'(lock), 24'h0);
    cyc(1, 0);
    chk(24'(lock), 24'h1);
    cyc(0, 0);
    chk(24'(lock), 24'h1);
    cyc(0, 1);
    chk(24'(lock), 24'h0);
    wr({4'h1, 18'($urandom), 2'h0});
    repeat (4) cyc(1, 0);
    chk(24'(lock), 24'h0);
    cyc(1, 0);
    chk(24'(lock), 24'h1);
    ce <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(24'(lock), 24'h0);
    end_of_test();
  end
endmodule // tb_top
